// ==== logic/psac_pkg.sv ====
package psac_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_SHADOW = 8'h38;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h40;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h44;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h48;

    // ****************************************
    // shared shadow register layout
    // ****************************************
    localparam int WE_BIT = 15;
    localparam int SEL_HI = 14;
    localparam int SEL_LO = 10;
    localparam logic [4:0] SEL_SPARE = 5'h04;
    localparam logic [4:0] SEL_APD = 5'h0a;
    localparam logic [4:0] SEL_RST = 5'h04;

    // spare control fields
    localparam int RETRY_HI = 4;
    localparam int RETRY_LO = 2;
    localparam int ROUTE_BIT = 1;
    localparam logic [2:0] RETRY_RST = 3'h3;
    localparam logic ROUTE_RST = 1'b0;
    localparam logic [3:0] RETRY_BIAS = 4'h2;

    // auto power-down fields
    localparam int APD_EN_BIT = 5;
    localparam int SLEEP_SEL_BIT = 4;
    localparam int WAKE_HI = 3;
    localparam int WAKE_LO = 0;
    localparam logic APD_EN_RST = 1'b0;
    localparam logic SLEEP_SEL_RST = 1'b0;
    localparam logic [3:0] WAKE_RST = 4'h1;

    // ****************************************
    // interrupt status layout
    // ****************************************
    localparam int INT_W = 4;
    localparam int INT_ED_CHG = 0;
    localparam int INT_DOWNGRADE = 1;
    localparam int INT_SLEEP = 2;
    localparam int INT_WAKE = 3;
    localparam logic [INT_W-1:0] INT_RST = 4'h0;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_FREQ_KHZ = 100000;
    localparam int unsigned SLEEP_SHORT_MS = 2700;
    localparam int unsigned SLEEP_LONG_MS = 5400;
    localparam int unsigned WAKE_UNIT_MS = 84;
    localparam int unsigned WAKE_CHECK_US = 1000;
    localparam logic [31:0] SLEEP_SHORT_CYC = 32'(SLEEP_SHORT_MS * CLK_FREQ_KHZ);
    localparam logic [31:0] SLEEP_LONG_CYC = 32'(SLEEP_LONG_MS * CLK_FREQ_KHZ);
    localparam logic [31:0] WAKE_UNIT_CYC = 32'(WAKE_UNIT_MS * CLK_FREQ_KHZ);
    localparam logic [31:0] WAKE_CHECK_CYC = 32'(WAKE_CHECK_US * CLK_FREQ_KHZ / 1000);

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } psac_bus_req_t;

    typedef struct packed {
        logic [2:0] retry;
        logic route;
    } psac_spare_t;

    typedef struct packed {
        logic en;
        logic sleep_sel;
        logic [3:0] wake;
    } psac_apd_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } psac_state_t;

endpackage

// ==== logic/psac_sync2.sv ====
`timescale 1ns/10ps
module psac_sync2 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_ff;
    logic q_ff;
    logic nxt_meta;
    logic nxt_q;

    // the first stage feeds only the second stage
    always_comb
    begin
        nxt_meta = d_i;
        nxt_q = meta_ff;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// ==== logic/psac_retry.sv ====
`timescale 1ns/10ps
module psac_retry
    import psac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic an_fail_i,
    input wire logic link_up_i,
    input wire logic [2:0] limit_i,
    output logic downgrade_o
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic dg_ff;
    logic nxt_dg;
    logic [3:0] target;

    assign target = {1'b0, limit_i} + RETRY_BIAS;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_dg = dg_ff;
        // a good link restarts the attempt count and lifts the downgrade
        if (link_up_i)
        begin
            nxt_cnt = 4'h0;
            nxt_dg = 1'b0;
        end
        else if (an_fail_i && !dg_ff)
        begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff + 4'h1 >= target)
            begin
                nxt_dg = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= 4'h0;
            dg_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            dg_ff <= nxt_dg;
        end
    end

    assign downgrade_o = dg_ff;

    a_retry_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(dg_ff) |-> $past(cnt_ff) + 4'h1 == $past(target) && $past(an_fail_i))
        else $error("downgrade not at retry limit plus two");
endmodule

// ==== logic/psac_top.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
// Contract
// - bit 15 set writes low ten bits
// - selector 00100 reaches spare control fields
// - selector 01010 reaches auto power-down fields
// - downgrade after retry field plus two failures
// - routing bit puts energy detect on pin
// - mode bit enables auto power-down, default off
// - sleep timer 5.4 s or 2.7 s
// - wake interval is field times 84 ms
module psac_top
    import psac_pkg::*;
#(
    parameter logic [31:0] SLEEP_SHORT_CYC_P = SLEEP_SHORT_CYC,
    parameter logic [31:0] SLEEP_LONG_CYC_P = SLEEP_LONG_CYC,
    parameter logic [31:0] WAKE_UNIT_CYC_P = WAKE_UNIT_CYC,
    parameter logic [31:0] WAKE_CHECK_CYC_P = WAKE_CHECK_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire psac_pkg::psac_bus_req_t bus_req_i,
    output logic [15:0] rdata_o,
    input wire logic energy_detect_i,
    input wire logic phy_interrupt_led_output_n_i,
    input wire logic an_fail_i,
    input wire logic link_up_i,
    output logic interrupt_led_output_n_o,
    output logic speed_downgrade_o,
    output logic low_power_o,
    output logic irq_o
);
    import psac_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    logic [4:0] sel_ff;
    logic [4:0] nxt_sel;
    psac_spare_t spare_ff;
    psac_spare_t nxt_spare;
    psac_apd_t apd_ff;
    psac_apd_t nxt_apd;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [INT_W-1:0] status_ff;
    logic [INT_W-1:0] nxt_status;
    logic [INT_W-1:0] enable_ff;
    logic [INT_W-1:0] nxt_enable;
    logic [INT_W-1:0] clr;
    logic [INT_W-1:0] ev;
    logic irq_ff;
    logic nxt_irq;
    logic led_n_ff;
    logic nxt_led_n;
    logic ed_s;
    logic ed_d_ff;
    logic dg;
    logic dg_d_ff;
    logic dg_out_ff;
    psac_state_t state_ff;
    psac_state_t nxt_state;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [31:0] cnt_inc;
    logic [31:0] sleep_thr;
    logic [31:0] wake_thr;
    logic lp_ff;
    logic nxt_lp;
    logic wr_shadow;
    logic [4:0] wsel;

    // ****************************************
    // read view of the shared shadow address
    // ****************************************
    // write enable reads back as zero; reserved bits read as zero
    function automatic logic [15:0] shadow_view(input logic [4:0] sel,
                                                input psac_spare_t sp,
                                                input psac_apd_t ap);
        logic [9:0] low;
        low = 10'h000;
        if (sel == SEL_SPARE)
        begin
            low[RETRY_HI:RETRY_LO] = sp.retry;
            low[ROUTE_BIT] = sp.route;
        end
        else if (sel == SEL_APD)
        begin
            low[APD_EN_BIT] = ap.en;
            low[SLEEP_SEL_BIT] = ap.sleep_sel;
            low[WAKE_HI:WAKE_LO] = ap.wake;
        end
        return {1'b0, sel, low};
    endfunction

    // ****************************************
    // synchronisers and sub-blocks
    // ****************************************
    psac_sync2 i_psac_sync2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(energy_detect_i),
        .q_o(ed_s)
    );

    psac_retry i_psac_retry (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .an_fail_i(an_fail_i),
        .link_up_i(link_up_i),
        .limit_i(spare_ff.retry),
        .downgrade_o(dg)
    );

    // ****************************************
    // shadow registers
    // ****************************************
    assign wr_shadow = bus_req_i.wr && (bus_req_i.addr == ADDR_SHADOW);
    assign wsel = bus_req_i.wdata[SEL_HI:SEL_LO];

    always_comb
    begin
        nxt_sel = sel_ff;
        nxt_spare = spare_ff;
        nxt_apd = apd_ff;
        if (wr_shadow)
        begin
            // every write picks the shadow; only bit 15 lets the fields change
            nxt_sel = wsel;
            if (bus_req_i.wdata[WE_BIT])
            begin
                // reserved bits are dropped on write
                if (wsel == SEL_SPARE)
                begin
                    nxt_spare.retry = bus_req_i.wdata[RETRY_HI:RETRY_LO];
                    nxt_spare.route = bus_req_i.wdata[ROUTE_BIT];
                end
                else if (wsel == SEL_APD)
                begin
                    nxt_apd.en = bus_req_i.wdata[APD_EN_BIT];
                    nxt_apd.sleep_sel = bus_req_i.wdata[SLEEP_SEL_BIT];
                    nxt_apd.wake = bus_req_i.wdata[WAKE_HI:WAKE_LO];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_ff <= SEL_RST;
            spare_ff <= '{retry: RETRY_RST, route: ROUTE_RST};
            apd_ff <= '{en: APD_EN_RST, sleep_sel: SLEEP_SEL_RST, wake: WAKE_RST};
        end
        else
        begin
            sel_ff <= nxt_sel;
            spare_ff <= nxt_spare;
            apd_ff <= nxt_apd;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb
    begin
        nxt_rdata = 16'h0000;
        if (bus_req_i.rd)
        begin
            if (bus_req_i.addr == ADDR_SHADOW)
            begin
                nxt_rdata = shadow_view(sel_ff, spare_ff, apd_ff);
            end
            else if (bus_req_i.addr == ADDR_INT_STATUS)
            begin
                nxt_rdata = {12'h000, status_ff};
            end
            else if (bus_req_i.addr == ADDR_INT_ENABLE)
            begin
                nxt_rdata = {12'h000, enable_ff};
            end
            else
            begin
                nxt_rdata = 16'h0000;
            end
        end
    end

    // ****************************************
    // interrupts and pin routing
    // ****************************************
    assign ev[INT_ED_CHG] = ed_s ^ ed_d_ff;
    assign ev[INT_DOWNGRADE] = dg & ~dg_d_ff;
    assign ev[INT_SLEEP] = (state_ff != ST_SLEEP) && (nxt_state == ST_SLEEP);
    assign ev[INT_WAKE] = (state_ff != ST_WAKE) && (nxt_state == ST_WAKE);
    assign clr = (bus_req_i.wr && bus_req_i.addr == ADDR_INT_CLEAR) ?
                 bus_req_i.wdata[INT_W-1:0] : INT_RST;

    always_comb
    begin
        // an event in the clearing cycle survives the clear
        nxt_status = (status_ff & ~clr) | ev;
        nxt_enable = enable_ff;
        if (bus_req_i.wr && bus_req_i.addr == ADDR_INT_ENABLE)
        begin
            nxt_enable = bus_req_i.wdata[INT_W-1:0];
        end
        nxt_irq = |(nxt_status & nxt_enable);
        // the pin is active low, so energy present pulls it low
        nxt_led_n = spare_ff.route ? ~ed_s : phy_interrupt_led_output_n_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status_ff <= INT_RST;
            enable_ff <= INT_RST;
            irq_ff <= 1'b0;
            led_n_ff <= 1'b1;
            ed_d_ff <= 1'b0;
            dg_d_ff <= 1'b0;
            dg_out_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
            irq_ff <= nxt_irq;
            led_n_ff <= nxt_led_n;
            ed_d_ff <= ed_s;
            dg_d_ff <= dg;
            dg_out_ff <= dg;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // auto power-down sequencer
    // ****************************************
    assign cnt_inc = cnt_ff + 32'h0000_0001;
    assign sleep_thr = apd_ff.sleep_sel ? SLEEP_LONG_CYC_P : SLEEP_SHORT_CYC_P;
    assign wake_thr = {28'h000_0000, apd_ff.wake} * WAKE_UNIT_CYC_P;

    // a wake field of zero simply means a check on every cycle out of sleep
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_inc;
        case (state_ff)
            ST_ACTIVE:
            begin
                if (!apd_ff.en || ed_s)
                begin
                    nxt_cnt = 32'h0000_0000;
                end
                else if (cnt_inc >= sleep_thr)
                begin
                    nxt_state = ST_SLEEP;
                    nxt_cnt = 32'h0000_0000;
                end
            end
            ST_SLEEP:
            begin
                if (!apd_ff.en || ed_s)
                begin
                    nxt_state = ST_ACTIVE;
                    nxt_cnt = 32'h0000_0000;
                end
                else if (cnt_inc >= wake_thr)
                begin
                    nxt_state = ST_WAKE;
                    nxt_cnt = 32'h0000_0000;
                end
            end
            ST_WAKE:
            begin
                if (!apd_ff.en || ed_s)
                begin
                    nxt_state = ST_ACTIVE;
                    nxt_cnt = 32'h0000_0000;
                end
                else if (cnt_inc >= WAKE_CHECK_CYC_P)
                begin
                    nxt_state = ST_SLEEP;
                    nxt_cnt = 32'h0000_0000;
                end
            end
            default:
            begin
                nxt_state = ST_ACTIVE;
                nxt_cnt = 32'h0000_0000;
            end
        endcase
        nxt_lp = (nxt_state == ST_SLEEP);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_ACTIVE;
            cnt_ff <= 32'h0000_0000;
            lp_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            lp_ff <= nxt_lp;
        end
    end

    assign rdata_o = rdata_ff;
    assign irq_o = irq_ff;
    assign interrupt_led_output_n_o = led_n_ff;
    assign speed_downgrade_o = dg_out_ff;
    assign low_power_o = lp_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_readback_sel: assert property (
        bus_req_i.rd && bus_req_i.addr == ADDR_SHADOW
        |=> rdata_o[SEL_HI:SEL_LO] == $past(sel_ff) && !rdata_o[WE_BIT])
        else $error("shadow readback selector wrong");
    a_write_gate: assert property (
        wr_shadow && !bus_req_i.wdata[WE_BIT] |=> $stable(spare_ff) && $stable(apd_ff))
        else $error("fields changed without write enable");
    a_spare_map: assert property (
        wr_shadow && bus_req_i.wdata[WE_BIT] && wsel == SEL_SPARE
        |=> spare_ff.retry == $past(bus_req_i.wdata[RETRY_HI:RETRY_LO])
            && $stable(apd_ff))
        else $error("spare control write misrouted");
    a_apd_map: assert property (
        wr_shadow && bus_req_i.wdata[WE_BIT] && wsel == SEL_APD
        |=> apd_ff.wake == $past(bus_req_i.wdata[WAKE_HI:WAKE_LO]) && $stable(spare_ff))
        else $error("power-down write misrouted");
    a_led_route: assert property (
        spare_ff.route && $stable(spare_ff.route) ##1 spare_ff.route
        |-> interrupt_led_output_n_o == !$past(ed_s))
        else $error("energy detect not routed to pin");
    a_apd_off: assert property (
        !apd_ff.en ##1 !apd_ff.en |-> state_ff == ST_ACTIVE && !low_power_o)
        else $error("power-down active while disabled");
    a_sleep_time: assert property (
        state_ff == ST_ACTIVE && nxt_state == ST_SLEEP |-> cnt_ff == sleep_thr - 32'h0000_0001)
        else $error("sleep entered at wrong time");
    a_wake_time: assert property (
        state_ff == ST_SLEEP && nxt_state == ST_WAKE && wake_thr != 32'h0000_0000
        |-> cnt_ff == wake_thr - 32'h0000_0001)
        else $error("wake check at wrong time");
    a_energy_wakes: assert property (
        state_ff != ST_ACTIVE && ed_s |=> state_ff == ST_ACTIVE ##1 !low_power_o)
        else $error("energy did not restore active state");
    a_set_wins: assert property (
        ev[INT_ED_CHG] && clr[INT_ED_CHG] |=> status_ff[INT_ED_CHG])
        else $error("event lost to clear");

    c_downgrade: cover property ($rose(speed_downgrade_o));
    c_sleep: cover property ($rose(low_power_o));
    c_wake_then_sleep: cover property (state_ff == ST_WAKE ##1 state_ff == ST_SLEEP);
    c_routed_pin: cover property (spare_ff.route && !interrupt_led_output_n_o);
endmodule

// ==== logic/psac_dummy_unused_marker.sv ====
`timescale 1ns/10ps

// ==== tb/psac_top_tb.sv ====
`timescale 1ns/10ps
module psac_top_tb;
    import psac_pkg::*;

    // ****************************************
    // stimulus and design
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    psac_bus_req_t bus_req = '0;
    logic [15:0] rdata_o;
    logic energy_detect_i = 1'b0;
    logic phy_interrupt_led_output_n_i = 1'b1;
    logic an_fail_i = 1'b0;
    logic link_up_i = 1'b0;
    logic interrupt_led_output_n_o;
    logic speed_downgrade_o;
    logic low_power_o;
    logic irq_o;
    int errors = 0;
    int check_count = 0;

    // short timer values keep the run brief; expectations below follow them
    psac_top #(
        .SLEEP_SHORT_CYC_P(32'h0000_0014),
        .SLEEP_LONG_CYC_P(32'h0000_0028),
        .WAKE_UNIT_CYC_P(32'h0000_0005),
        .WAKE_CHECK_CYC_P(32'h0000_0003)
    ) i_psac_top (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus_req_i(bus_req),
        .rdata_o(rdata_o),
        .energy_detect_i(energy_detect_i),
        .phy_interrupt_led_output_n_i(phy_interrupt_led_output_n_i),
        .an_fail_i(an_fail_i),
        .link_up_i(link_up_i),
        .interrupt_led_output_n_o(interrupt_led_output_n_o),
        .speed_downgrade_o(speed_downgrade_o),
        .low_power_o(low_power_o),
        .irq_o(irq_o)
    );

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic chk_rng(input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi)
        begin
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
            errors++;
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus_req <= '0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_i);
        bus_req <= '0;
        #1 d = rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] d;
        bus_rd(a, d);
        chk(d & mask, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // bounded wait for low_power_o to reach v; n counts the edges taken
    task automatic wait_lp(input logic v, input int lim, output int n);
        n = 0;
        while (low_power_o !== v)
        begin
            @(posedge clk_i);
            #1 n++;
            if (n > lim)
            begin
                $display("mismatch t=%0t got=%h exp=%h", $time, low_power_o, v);
                errors++;
                report_and_stop();
            end
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        chk({irq_o, low_power_o, speed_downgrade_o, interrupt_led_output_n_o}, 16'h0001);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h100c);
        bus_wr(ADDR_SHADOW, 16'h2800);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h2801);
        rd_chk(ADDR_INT_STATUS, 16'hffff, 16'h0000);
        rd_chk(ADDR_INT_ENABLE, 16'hffff, 16'h0000);
    endtask

    task automatic t_shadow_write();
        // reserved bits stay zero on every field write
        bus_wr(ADDR_SHADOW, 16'h901e);
        bus_wr(ADDR_SHADOW, 16'h2800);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h2801);
        bus_wr(ADDR_SHADOW, 16'ha837);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h2837);
        bus_wr(ADDR_SHADOW, 16'h1000);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h101e);
        bus_wr(ADDR_SHADOW, 16'h1000);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h101e);
        bus_wr(ADDR_SHADOW, 16'hfc3f);
        bus_wr(ADDR_SHADOW, 16'h2800);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h2837);
        bus_wr(ADDR_SHADOW, 16'ha801);
        bus_wr(ADDR_SHADOW, 16'h900c);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h100c);
    endtask

    task automatic t_route();
        @(posedge clk_i) phy_interrupt_led_output_n_i <= 1'b0;
        cycles(2);
        chk(interrupt_led_output_n_o, 1'b0);
        @(posedge clk_i) phy_interrupt_led_output_n_i <= 1'b1;
        cycles(2);
        chk(interrupt_led_output_n_o, 1'b1);
        bus_wr(ADDR_SHADOW, 16'h900e);
        // write enable with unmapped selector 01110; only the selector sticks here
        bus_wr(ADDR_SHADOW, 16'hb866);
        rd_chk(ADDR_SHADOW, 16'hffff, 16'h3800);
        @(posedge clk_i) phy_interrupt_led_output_n_i <= 1'b0;
        cycles(3);
        chk(interrupt_led_output_n_o, 1'b1);
        @(posedge clk_i) energy_detect_i <= 1'b1;
        cycles(4);
        chk(interrupt_led_output_n_o, 1'b0);
        @(posedge clk_i) energy_detect_i <= 1'b0;
        cycles(4);
        chk(interrupt_led_output_n_o, 1'b1);
        @(posedge clk_i) phy_interrupt_led_output_n_i <= 1'b1;
        bus_wr(ADDR_SHADOW, 16'h900c);
    endtask

    task automatic t_irq();
        bus_wr(ADDR_INT_CLEAR, 16'h000f);
        bus_wr(ADDR_INT_ENABLE, 16'h0001);
        rd_chk(ADDR_INT_ENABLE, 16'hffff, 16'h0001);
        cycles(1);
        chk(irq_o, 1'b0);
        @(posedge clk_i) energy_detect_i <= 1'b1;
        cycles(4);
        chk(irq_o, 1'b1);
        @(posedge clk_i) energy_detect_i <= 1'b0;
        cycles(4);
        rd_chk(ADDR_INT_STATUS, 16'hffff, 16'h0001);
        bus_wr(ADDR_INT_ENABLE, 16'h0000);
        cycles(1);
        chk(irq_o, 1'b0);
        bus_wr(ADDR_INT_ENABLE, 16'h0001);
        cycles(1);
        chk(irq_o, 1'b1);
        bus_wr(ADDR_INT_CLEAR, 16'h0001);
        cycles(1);
        chk(irq_o, 1'b0);
        rd_chk(ADDR_INT_STATUS, 16'hffff, 16'h0000);
        rd_chk(ADDR_INT_CLEAR, 16'hffff, 16'h0000);
        bus_wr(8'h50, 16'hffff);
        rd_chk(8'h50, 16'hffff, 16'h0000);
        bus_wr(ADDR_INT_ENABLE, 16'h0000);
        // an energy change landing in the clearing cycle must survive the clear
        @(posedge clk_i) energy_detect_i <= 1'b1;
        @(posedge clk_i);
        bus_wr(ADDR_INT_CLEAR, 16'h0001);
        rd_chk(ADDR_INT_STATUS, 16'h0001, 16'h0001);
        @(posedge clk_i) energy_detect_i <= 1'b0;
        cycles(4);
        bus_wr(ADDR_INT_CLEAR, 16'h000f);
    endtask

    // one-cycle pulse on an_fail_i when fail is set, else on link_up_i
    task automatic pulse(input logic fail);
        @(posedge clk_i)
        begin
            an_fail_i <= fail;
            link_up_i <= !fail;
        end
        @(posedge clk_i)
        begin
            an_fail_i <= 1'b0;
            link_up_i <= 1'b0;
        end
    endtask

    task automatic t_retry();
        for (int lim = 0; lim < 8; lim++)
        begin
            bus_wr(ADDR_SHADOW, 16'h9000 | 16'(lim << 2));
            pulse(1'b0);
            cycles(2);
            chk(speed_downgrade_o, 1'b0);
            repeat (lim + 1) pulse(1'b1);
            cycles(4);
            chk(speed_downgrade_o, 1'b0);
            pulse(1'b1);
            cycles(2);
            chk(speed_downgrade_o, 1'b1);
        end
        rd_chk(ADDR_INT_STATUS, 16'h0002, 16'h0002);
        pulse(1'b0);
        cycles(2);
        chk(speed_downgrade_o, 1'b0);
        bus_wr(ADDR_SHADOW, 16'h900c);
    endtask

    task automatic t_apd();
        int n;
        bus_wr(ADDR_INT_CLEAR, 16'h000f);
        cycles(30);
        chk(low_power_o, 1'b0);
        bus_wr(ADDR_SHADOW, 16'ha822);
        wait_lp(1'b1, 60, n);
        chk_rng(n, 18, 24);
        wait_lp(1'b0, 40, n);
        chk_rng(n, 8, 13);
        wait_lp(1'b1, 20, n);
        chk_rng(n, 2, 5);
        rd_chk(ADDR_INT_STATUS, 16'h000c, 16'h000c);
        @(posedge clk_i) energy_detect_i <= 1'b1;
        wait_lp(1'b0, 6, n);
        cycles(40);
        chk(low_power_o, 1'b0);
        @(posedge clk_i) energy_detect_i <= 1'b0;
        bus_wr(ADDR_SHADOW, 16'ha832);
        wait_lp(1'b1, 80, n);
        chk_rng(n, 36, 46);
        bus_wr(ADDR_SHADOW, 16'ha802);
        wait_lp(1'b0, 4, n);
        for (int i = 0; i < 60; i++)
        begin
            cycles(1);
            if (low_power_o !== 1'b0)
                chk(low_power_o, 1'b0);
        end
        chk(low_power_o, 1'b0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cycles(1);
        t_reset_values();
        t_shadow_write();
        t_route();
        t_irq();
        t_retry();
        t_apd();
        report_and_stop();
    end

endmodule
